// ===== rtrc_adc_model.sv
// Purpose: front end stand-in giving raw codes and diode fault flags
// Assumes: raw code is wanted on the core clock, sampled at conv end
// Notes: channels without a diode return a code that changes every cycle
`timescale 1ns/1ps
module rtrc_adc_model #(
  parameter logic [6:0] OPEN_MASK = 7'h78
) (
  input wire logic core_clk,
  input wire logic [2:0] conv_channel,
  input wire logic all_open, // every diode disconnected
  output logic [6:0] diode_fault_raw,
  output logic [10:0] adc_result = 11'h000
);
  // open or shorted diodes trip their fault comparators
  assign diode_fault_raw = all_open ? 7'h7F : OPEN_MASK;
  // raw codes near both range ends, so clamps are reachable
  always @(negedge core_clk) begin
    case (conv_channel)
      3'h1: adc_result <= 11'h7FC;
      3'h2: adc_result <= 11'h100;
      3'h3: adc_result <= 11'h004;
      // no diode: never a stable code
      default: adc_result <= ~adc_result;
    endcase
  end
endmodule

// ===== rtrc_core.sv
// Purpose: remote channel sequencing, offset and clamp of results
// Assumes: register port already decoded from the two-wire interface
// Notes: adc_result is same-clock data, sampled at conversion end
`timescale 1ns/1ps
`include "rtrc_regs.svh"
module rtrc_core #(
  parameter int unsigned BASE_CYC = `RTRC_BASE_CYC,
  parameter int unsigned CANCEL_CYC = `RTRC_CANCEL_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [6:0] diode_fault_raw,
  input wire logic extended_range_select,
  input wire logic [10:0] adc_result,
  output logic conv_active,
  output logic [2:0] conv_channel,
  output logic conv_cancel,
  output logic [6:0] diode_fault_status,
  output logic result_valid,
  output logic [2:0] result_channel,
  output logic [10:0] result_temp
);
  // *************************************
  // reset release and input sync
  // *************************************
  logic rst_q1, rst_n; // reset release pair
  logic [6:0] flt_q1, flt_q2; // fault comparator sync

  // reset asserts at once, releases after two edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // fault levels come from the analog side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flt_q1 <= 7'h00;
      flt_q2 <= 7'h00;
    end else begin
      flt_q1 <= diode_fault_raw;
      flt_q2 <= flt_q1;
    end
  end

  // *************************************
  // registers
  // *************************************
  logic [7:0] series_resistance_cancel_enable;
  logic [7:0] shared_temperature_offset;
  logic [7:0] offset_channel_select;
  logic [7:0] next_cancel, next_offset, next_select, next_rdata;
  logic [6:0] next_fault;

  // write decode; channel bit 7 never stored
  always_comb begin
    next_cancel = series_resistance_cancel_enable;
    next_offset = shared_temperature_offset;
    next_select = offset_channel_select;
    next_rdata = reg_rdata;
    next_fault = flt_q2;
    if (reg_wr) begin
      unique case (reg_addr)
        `RTRC_CANCEL_OFS: next_cancel = reg_wdata & `RTRC_CHAN_MASK;
        `RTRC_OFFSET_OFS: next_offset = reg_wdata;
        `RTRC_SELECT_OFS: next_select = reg_wdata & `RTRC_CHAN_MASK;
        default: ; // other offsets belong elsewhere
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `RTRC_CANCEL_OFS: next_rdata = series_resistance_cancel_enable;
        `RTRC_OFFSET_OFS: next_rdata = shared_temperature_offset;
        `RTRC_SELECT_OFS: next_rdata = offset_channel_select;
        default: next_rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // all three clear on reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      series_resistance_cancel_enable <= `RTRC_REG_RST;
      shared_temperature_offset <= `RTRC_REG_RST;
      offset_channel_select <= `RTRC_REG_RST;
      reg_rdata <= 8'h00;
      diode_fault_status <= 7'h00;
    end else begin
      series_resistance_cancel_enable <= next_cancel;
      shared_temperature_offset <= next_offset;
      offset_channel_select <= next_select;
      reg_rdata <= next_rdata;
      diode_fault_status <= next_fault;
    end
  end

  // *************************************
  // helpers
  // *************************************
  // next healthy channel after cur, wrapping; cur if none
  function automatic logic [2:0] pick(input logic [2:0] cur,
                                      input logic [6:0] flt);
    logic [2:0] r;
    logic [2:0] c;
    r = cur;
    for (int i = 6; i >= 0; i--) begin
      c = 3'((32'(cur) + 32'd1 + 32'(i)) % 32'd7);
      if (!flt[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  // *************************************
  // sequencer
  // *************************************
  rtrc_pkg::rtrc_state_t st, next_st;
  logic [2:0] chan, next_chan; // 0..6 stands for channel 1..7
  logic [23:0] cnt, next_cnt; // conversion countdown
  logic [10:0] adc_cap, next_cap; // raw result held for post step
  logic next_active, next_cancel_o, next_valid;
  logic [2:0] next_rchan;
  logic [10:0] next_temp;
  logic signed [13:0] sum; // raw plus offset, 0.125 degree lsb

  // offset lsb is 0.25 degree, so it doubles into result lsb
  always_comb begin
    sum = $signed({3'b000, adc_cap});
    if (offset_channel_select[chan]) begin
      sum = sum + 14'($signed(shared_temperature_offset) * 2);
    end
  end

  // clamp follows the add, both ends always guarded
  always_comb begin
    next_st = st;
    next_chan = chan;
    next_cnt = cnt;
    next_cap = adc_cap;
    next_valid = 1'b0;
    next_rchan = result_channel;
    next_temp = result_temp;
    next_cancel_o = conv_cancel; // held for the running conversion
    unique case (st)
      rtrc_pkg::ST_SEL: begin
        // all faulted: wait here, nothing measured
        if (!flt_q2[pick(chan, flt_q2)]) begin
          next_chan = pick(chan, flt_q2);
          next_st = rtrc_pkg::ST_CONV;
          // flag frozen for the whole conversion, so a late write
          // cannot make it disagree with the length chosen here
          next_cancel_o = series_resistance_cancel_enable[next_chan];
          if (next_cancel_o) begin
            next_cnt = 24'(BASE_CYC + CANCEL_CYC - 1);
          end else begin
            next_cnt = 24'(BASE_CYC - 1);
          end
        end
      end
      rtrc_pkg::ST_CONV: begin
        if (cnt == 24'h000000) begin
          next_cap = adc_result;
          next_st = rtrc_pkg::ST_POST;
        end else begin
          next_cnt = cnt - 24'h000001;
        end
      end
      rtrc_pkg::ST_POST: begin
        next_valid = 1'b1;
        next_rchan = chan + 3'h1;
        if (sum < 14'sh0000) begin
          next_temp = `RTRC_CODE_MIN;
        end else if (sum > $signed({3'b000, `RTRC_CODE_MAX})) begin
          next_temp = `RTRC_CODE_MAX;
        end else begin
          next_temp = sum[10:0];
        end
        next_st = rtrc_pkg::ST_SEL;
      end
      default: next_st = rtrc_pkg::ST_SEL;
    endcase
    next_active = (next_st == rtrc_pkg::ST_CONV);
  end

  // register sequencer state and outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= rtrc_pkg::ST_SEL;
      chan <= 3'h6; // first pick lands on channel 1
      cnt <= 24'h000000;
      adc_cap <= 11'h000;
      conv_active <= 1'b0;
      conv_channel <= 3'h0;
      conv_cancel <= 1'b0;
      result_valid <= 1'b0;
      result_channel <= 3'h0;
      result_temp <= 11'h000;
    end else begin
      st <= next_st;
      chan <= next_chan;
      cnt <= next_cnt;
      adc_cap <= next_cap;
      conv_active <= next_active;
      conv_channel <= next_chan + 3'h1;
      conv_cancel <= next_cancel_o;
      result_valid <= next_valid;
      result_channel <= next_rchan;
      result_temp <= next_temp;
    end
  end

  // *************************************
  // checks
  // *************************************
  logic [23:0] conv_len; // cycles spent converting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_len <= 24'h000000;
    end else begin
      conv_len <= (st == rtrc_pkg::ST_CONV) ? conv_len + 24'h000001
                                            : 24'h000000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_cancel_bit_seven: assert property (
    !series_resistance_cancel_enable[7] && !offset_channel_select[7])
    else $error("channel register bit 7 stored");
  a_offset_write: assert property (
    reg_wr && reg_addr == `RTRC_OFFSET_OFS
    |=> shared_temperature_offset == $past(reg_wdata))
    else $error("offset write lost");
  a_select_write: assert property (
    reg_wr && reg_addr == `RTRC_SELECT_OFS
    |=> offset_channel_select[6:0] == $past(reg_wdata[6:0]))
    else $error("select write lost");
  a_cancel_length: assert property (
    st == rtrc_pkg::ST_CONV ##1 st != rtrc_pkg::ST_CONV
    |-> $past(conv_len) == 24'(conv_cancel ? BASE_CYC + CANCEL_CYC - 1
                                          : BASE_CYC - 1))
    else $error("conversion length wrong");
  a_all_faulted_hold: assert property (
    st == rtrc_pkg::ST_SEL && &flt_q2 |=> st == rtrc_pkg::ST_SEL)
    else $error("faulted channel measured");
  // sampled rst_n keeps out the release edge, where state is still held
  a_healthy_start: assert property (
    rst_n && st == rtrc_pkg::ST_SEL && !(&flt_q2)
    |=> st == rtrc_pkg::ST_CONV && conv_active)
    else $error("healthy channel not started");
  a_floor_clamp: assert property (
    st == rtrc_pkg::ST_POST && sum < 14'sh0000
    |=> result_valid && result_temp == `RTRC_CODE_MIN)
    else $error("result below floor");
  a_ceiling_clamp: assert property (
    st == rtrc_pkg::ST_POST && sum > 14'sh07FF
    |=> result_valid && result_temp == `RTRC_CODE_MAX)
    else $error("result above ceiling");
  a_no_offset: assert property (
    st == rtrc_pkg::ST_POST && !offset_channel_select[chan]
    |=> result_temp == $past(adc_cap))
    else $error("offset applied to unselected channel");

  c_cancel_conv: cover property (
    st == rtrc_pkg::ST_CONV && conv_cancel ##1 st == rtrc_pkg::ST_POST);
  c_floor: cover property (st == rtrc_pkg::ST_POST && sum < 14'sh0000);
  c_all_faulted: cover property (st == rtrc_pkg::ST_SEL && &flt_q2);
endmodule

// ===== rtrc_pkg.sv
// Purpose: types shared by the remote result correction block
// Assumes: nothing beyond the constants header
// Notes: sequencer states only
package rtrc_pkg;
  // sequencer states, 2'b11 never used
  typedef enum logic [1:0] {
    ST_SEL = 2'b00,
    ST_CONV = 2'b01,
    ST_POST = 2'b10
  } rtrc_state_t;
endpackage

// ===== rtrc_regs.svh
// Purpose: constants for the remote result correction block
// Assumes: 10 MHz core clock, byte wide register port
// Notes: offsets, field positions, reset values and timing counts
`ifndef RTRC_REGS_SVH
`define RTRC_REGS_SVH
// *************************************
// register map
// *************************************
`define RTRC_CANCEL_OFS 8'h4A
`define RTRC_OFFSET_OFS 8'h4D
`define RTRC_SELECT_OFS 8'h4E
`define RTRC_REG_RST 8'h00
`define RTRC_CHAN_MASK 8'h7F
`define RTRC_SIGN_BIT 7
// *************************************
// result codes, 0.125 degree per lsb
// *************************************
`define RTRC_CODE_MIN 11'h000
`define RTRC_CODE_MAX 11'h7FF
// *************************************
// timing
// *************************************
`define RTRC_CLK_HZ 10000000
`define RTRC_CANCEL_MS 125
`define RTRC_CANCEL_CYC (`RTRC_CANCEL_MS * (`RTRC_CLK_HZ / 1000))
`define RTRC_BASE_CYC 1000000
`endif

// ===== test_remote_temp_result_correction.sv
// Purpose: register access and corrected result checks
// Assumes: channels 4 to 7 open, short conversion counts
// Notes: expected codes come from the bench's own shadow registers
`timescale 1ns/1ps
module test_remote_temp_result_correction;
  // *****************
  // signals
  // *****************
  logic core_clk, rstn, reg_wr, reg_rd, extended_range_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [6:0] diode_fault_raw, diode_fault_status;
  logic [10:0] adc_result, result_temp;
  logic conv_active, conv_cancel, result_valid, all_open;
  logic [2:0] conv_channel, result_channel;
  logic [7:0] off_sh, sel_sh, can_sh; // shadow register copies
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int raw_tab [3] = '{12'h7FC, 12'h100, 12'h004};
  localparam int BASE = 20;
  localparam int CANC = 10;
  rtrc_core #(.BASE_CYC(BASE), .CANCEL_CYC(CANC)) rtrc_core_inst (
    .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .diode_fault_raw(diode_fault_raw),
    .extended_range_select(extended_range_select),
    .adc_result(adc_result), .conv_active(conv_active),
    .conv_channel(conv_channel), .conv_cancel(conv_cancel),
    .diode_fault_status(diode_fault_status), .result_valid(result_valid),
    .result_channel(result_channel), .result_temp(result_temp));
  rtrc_adc_model rtrc_adc_model_inst (.core_clk(core_clk),
    .all_open(all_open),
    .conv_channel(conv_channel), .diode_fault_raw(diode_fault_raw),
    .adc_result(adc_result));
  // *****************
  // tasks
  // *****************
  // 100 ns period core clock
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard, well above the expected few hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
        exp);
    end
  endtask
  // one cycle write strobe, driven at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 0;
  endtask
  // read data lands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // one conversion: channel, length, then the corrected result
  task automatic get_result(input int ch);
    int n;
    int exp;
    logic [2:0] cch;
    logic ccan;
    n = 0;
    while (conv_active !== 1'b1) @(negedge core_clk);
    cch = conv_channel;
    ccan = conv_cancel;
    while (conv_active === 1'b1) begin
      n++;
      @(negedge core_clk);
    end
    check(cch, ch);
    check(ccan, can_sh[ch-1]);
    check(n, BASE + (can_sh[ch-1] ? CANC : 0));
    exp = raw_tab[ch-1];
    if (sel_sh[ch-1]) exp = exp + 2 * int'($signed(off_sh));
    if (exp < 0) exp = 0;
    if (exp > 2047) exp = 2047;
    @(negedge core_clk);
    check(result_valid, 1'b1);
    check(result_channel, ch);
    check(result_temp, exp);
  endtask
  // verdict; the only place the run ends
  task automatic complete_run();
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // *****************
  // main sequence
  // *****************
  initial begin
    rstn = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    extended_range_select = 1;
    // channels 4..7 open from power up; alarm masks live elsewhere
    all_open = 0;
    off_sh = 8'h04;
    sel_sh = 8'h05;
    can_sh = 8'h01;
    repeat (16) @(negedge core_clk);
    rstn = 1;
    repeat (3) @(negedge core_clk);
    // reset values of the three mapped registers
    foreach (raw_tab[i]) begin
      rd(8'h4A + 8'(i * 3 + (i == 2 ? -2 : 0)), rv);
      check(rv, 8'h00);
    end
    check(diode_fault_status, 7'h78);
    // bit 7 dropped on the two channel masks
    wr(8'h4A, 8'hFF);
    rd(8'h4A, rv);
    check(rv, 8'h7F);
    wr(8'h4E, 8'hFF);
    rd(8'h4E, rv);
    check(rv, 8'h7F);
    wr(8'h4F, 8'hAA);
    rd(8'h4F, rv);
    check(rv, 8'h00);
    wr(8'h4D, off_sh);
    rd(8'h4D, rv);
    check(rv, 8'h04);
    wr(8'h4A, can_sh);
    wr(8'h4E, sel_sh);
    // drop conversions begun under the old settings
    while (!(result_valid === 1'b1 && result_channel === 3'h3))
      @(negedge core_clk);
    // round two swaps to a negative offset during channel 1
    for (int r = 0; r < 2; r++) begin
      for (int c = 1; c <= 3; c++) begin
        if (r == 1 && c == 1) fork
          get_result(c);
          begin
            repeat (5) @(negedge core_clk);
            extended_range_select = 0;
            wr(8'h4D, 8'hF8);
            off_sh = 8'hF8;
          end
        join
        else get_result(c);
      end
    end
    // every diode open: sequence idles once the running one ends
    all_open = 1;
    repeat (40) @(negedge core_clk);
    check(diode_fault_status, 7'h7F);
    repeat (8) begin
      @(negedge core_clk);
      check(conv_active, 1'b0);
    end
    complete_run();
  end
endmodule
